// >>> core/sci_async_receiver.sv
// Notes on behaviour
// - Character length is 8 or 9 data bits, chosen by a control bit.
// - Ninth-bit field holds bit 8, or a copy of bit 7 in 8-bit mode.
// - A complete character moves into the data buffer and sets full.
// - Interrupt request stands while full and receive interrupt enable.
// - Data buffer is read-only from the bus, loaded only by the shifter.
// - Input is sampled at 16 times the baud rate, 16 phases per bit.
// - Phase counter is resynchronised after every start bit.
// - A data bit voting 1 then one voting 0 resynchronises the phase.
// - A 0 after three 1 samples starts the phase count.
// - Start verified at phases 3,5,7; one 1 passes but flags noise.
// - Failed start verification clears the three-sample history and hunts again.
// - Data bits take majority of phases 8-10; disagreement flags noise.
// - Any 1 at start-bit phases 8-10 flags noise, start still taken.
// - Stop majority 0 is a framing error; disagreement flags noise.
// - Framing error is set in the same cycle as receiver full.
// - A break character sets the framing error flag.
// - Phase realigns on valid falling edges within a character.
// - Stop bit starting as late as phase 8 gives no error.
// - Stop bit ending as early as phase 10 gives no error.
// - Overrun keeps the old character and discards the new one.
// - Break clears data and ninth bit, sets break, framing and full.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module sci_async_receiver
   import sci_rx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rxd_pin,
   output logic rx_irq
);

   typedef struct packed {
      logic [7:0] ctrl_one;
      logic irq_en;
      logic [15:0] divisor;
      logic [7:0] data_buf;
      logic ninth;
      logic full;
      logic overrun;
      logic noise;
      logic frame;
      logic brk;
      logic [31:0] prdata;
      rx_state_t st;
      logic [4:0] phase;
      logic [3:0] bit_idx;
      logic [2:0] hist;
      logic [2:0] smp;
      logic [8:0] shreg;
      logic noise_acc;
      logic all_zero;
      logic prev_one;
      logic last_smp;
   } rx_regs_t;

   rx_regs_t q, d;

   sci_rx_if smp_if ();

   sci_rx_sampler u_sampler (
      .pclk(pclk),
      .presetn(presetn),
      .rxd_pin(rxd_pin),
      .divisor(q.divisor),
      .smp(smp_if.source)
   );

   logic s;
   logic nine;
   logic rx_en;
   logic acc_wr;
   logic acc_rd;
   logic data_read;
   logic mapped;
   logic complete;
   logic edge_seen;
   logic last_bit;
   logic [2:0] v;
   logic stop_ok;
   logic is_brk;
   logic [4:0] ph_next;

   assign s = smp_if.rxd;
   assign nine = q.ctrl_one[NINE_BIT_POS];
   assign rx_en = q.ctrl_one[RX_ENABLE_POS];
   assign acc_wr = psel && penable && pwrite;
   assign acc_rd = psel && penable && !pwrite;
   assign data_read = acc_rd && (paddr == OFS_DATA);
   assign mapped = (paddr == OFS_CTRL_ONE) || (paddr == OFS_CTRL_TWO) ||
                   (paddr == OFS_CTRL_THREE) || (paddr == OFS_DATA) ||
                   (paddr == OFS_STATUS_ONE);
   assign v = {q.smp[1:0], s};
   assign last_bit = (q.bit_idx == (nine ? 4'h8 : 4'h7));
   assign ph_next = (q.phase == PH_LAST) ? PH_FIRST : q.phase + 5'h01;
   // A valid falling edge follows a bit that voted 1
   assign edge_seen = q.prev_one && q.last_smp && !s;
   assign stop_ok = majority3(v);
   assign is_brk = !stop_ok && q.all_zero;
   assign complete = smp_if.tick && rx_en && (q.st == ST_STOP) &&
                     (q.phase == PH_10);

   // ----------------------------------------------------------------
   // Bus answers
   // ----------------------------------------------------------------
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = q.prdata;
   assign rx_irq = q.full && q.irq_en;

   always_comb
   begin
      d = q;

      // Read data is captured in the setup cycle so it leaves a flop
      if (psel && !penable)
      begin
         d.prdata = 32'h0000_0000;
         case (paddr)
            OFS_CTRL_ONE: d.prdata[7:0] = q.ctrl_one;
            OFS_CTRL_TWO:
            begin
               d.prdata[IRQ_EN_POS] = q.irq_en;
               d.prdata[NINTH_POS] = q.ninth;
            end
            OFS_CTRL_THREE: d.prdata[15:0] = q.divisor;
            OFS_DATA: d.prdata[7:0] = q.data_buf;
            OFS_STATUS_ONE:
            begin
               d.prdata[FULL_POS] = q.full;
               d.prdata[OVERRUN_POS] = q.overrun;
               d.prdata[NOISE_POS] = q.noise;
               d.prdata[FRAME_POS] = q.frame;
               d.prdata[BREAK_POS] = q.brk;
            end
            default: d.prdata = 32'h0000_0000;
         endcase
      end

      // Data buffer has no write path from the bus
      if (acc_wr)
      begin
         case (paddr)
            OFS_CTRL_ONE: d.ctrl_one = pwdata[7:0];
            OFS_CTRL_TWO: d.irq_en = pwdata[IRQ_EN_POS];
            OFS_CTRL_THREE: d.divisor = pwdata[15:0];
            default: d.ctrl_one = q.ctrl_one;
         endcase
      end

      // Reading the character acknowledges it and its error flags
      if (data_read)
      begin
         d.full = 1'b0;
         d.overrun = 1'b0;
         d.noise = 1'b0;
         d.frame = 1'b0;
         d.brk = 1'b0;
      end

      // --------------------------------------------------------------
      // Receive engine, one step per oversample phase
      // --------------------------------------------------------------
      if (!rx_en)
      begin
         d.st = ST_HUNT;
         d.hist = 3'b000;
      end
      else if (smp_if.tick)
      begin
         d.last_smp = s;
         d.phase = ph_next;
         case (q.st)
            ST_HUNT:
            begin
               d.hist = {q.hist[1:0], s};
               if (q.hist == 3'b111 && !s)
               begin
                  // The edge sample counts as the first phase
                  d.st = ST_START;
                  d.phase = PH_AFTER_EDGE;
                  d.smp = 3'b000;
                  d.noise_acc = 1'b0;
                  d.all_zero = 1'b1;
                  d.prev_one = 1'b0;
               end
            end
            ST_START:
            begin
               if (q.phase == PH_3 || q.phase == PH_5)
                  d.smp = {q.smp[1:0], s};
               if (q.phase == PH_7)
               begin
                  if (v == 3'b011 || v[2] + v[1] + v[0] > 2'd1)
                  begin
                     d.st = ST_HUNT;
                     d.hist = 3'b000;
                  end
                  else if (v != 3'b000)
                     d.noise_acc = 1'b1;
               end
               if (q.phase >= PH_8 && q.phase <= PH_10 && s)
                  d.noise_acc = 1'b1;
               if (q.phase == PH_LAST)
               begin
                  d.st = ST_DATA;
                  d.phase = PH_FIRST;
                  d.bit_idx = 4'h0;
               end
            end
            ST_DATA:
            begin
               if (q.phase >= PH_8 && q.phase <= PH_10)
                  d.smp = {q.smp[1:0], s};
               if (q.phase == PH_10)
               begin
                  d.shreg[q.bit_idx] = majority3(v);
                  d.prev_one = majority3(v);
                  if (majority3(v))
                     d.all_zero = 1'b0;
                  if (disagree3(v))
                     d.noise_acc = 1'b1;
               end
               // Edge early in a bit pulls the phase back, late in a bit
               // it opens the next bit: this absorbs sender drift
               if (edge_seen && (q.phase >= PH_11 || (q.phase >= PH_AFTER_EDGE
                   && q.phase <= PH_4)))
               begin
                  d.phase = PH_AFTER_EDGE;
                  d.prev_one = 1'b0;
                  if (q.phase >= PH_11)
                  begin
                     d.bit_idx = q.bit_idx + 4'h1;
                     if (last_bit)
                        d.st = ST_STOP;
                  end
               end
               else if (q.phase == PH_LAST)
               begin
                  d.bit_idx = q.bit_idx + 4'h1;
                  if (last_bit)
                     d.st = ST_STOP;
               end
            end
            ST_STOP:
            begin
               // Only phases 8-10 matter, so late or early edges of the
               // stop bit outside that span pass clean
               if (q.phase >= PH_8 && q.phase <= PH_10)
                  d.smp = {q.smp[1:0], s};
               if (q.phase == PH_10)
               begin
                  d.st = ST_HUNT;
                  d.hist = v;
                  d.prev_one = 1'b0;
               end
            end
            default:
            begin
               d.st = ST_HUNT;
               d.hist = 3'b000;
            end
         endcase
      end

      // --------------------------------------------------------------
      // Character completion; the set wins over a read in this cycle
      // --------------------------------------------------------------
      if (complete)
      begin
         if (q.full && !data_read)
            d.overrun = 1'b1;
         else
         begin
            d.full = 1'b1;
            d.data_buf = is_brk ? 8'h00 : q.shreg[7:0];
            d.ninth = is_brk ? 1'b0 : (nine ? q.shreg[8] : q.shreg[7]);
            d.frame = d.frame | !stop_ok;
            d.noise = d.noise | q.noise_acc | disagree3(v);
            d.brk = d.brk | is_brk;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
         q.ctrl_one <= CTRL_ONE_RST;
         q.divisor <= DIV_RST;
         q.st <= ST_HUNT;
         q.phase <= PH_FIRST;
         q.all_zero <= 1'b1;
         q.last_smp <= 1'b1;
      end
      else
         q <= d;
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   irq_tracks_full_a: assert property (
      complete && !q.full && q.irq_en &&
      !(acc_wr && paddr == OFS_CTRL_TWO)
      |=> rx_irq)
      else $error("receive interrupt missing after a character");

   start_edge_a: assert property (
      smp_if.tick && rx_en && q.st == ST_HUNT && q.hist == 3'b111 && !s
      |=> q.st == ST_START && q.phase == PH_AFTER_EDGE)
      else $error("start edge not taken");

   start_reject_a: assert property (
      smp_if.tick && rx_en && q.st == ST_START && q.phase == PH_7 &&
      (v == 3'b011 || v == 3'b101 || v == 3'b110 || v == 3'b111)
      |=> q.st == ST_HUNT && q.hist == 3'b000)
      else $error("bad start bit not rejected");

   start_resync_a: assert property (
      smp_if.tick && rx_en && q.st == ST_START && q.phase == PH_LAST
      |=> q.st == ST_DATA && q.phase == PH_FIRST && q.bit_idx == 4'h0)
      else $error("phase not resynchronised after start");

   frame_with_full_a: assert property (
      $rose(q.frame) |-> $rose(q.full) || q.full)
      else $error("framing error without receiver full");

   break_effects_a: assert property (
      $rose(q.brk) |-> q.data_buf == 8'h00 && !q.ninth && q.frame && q.full)
      else $error("break character effects wrong");

   overrun_keeps_a: assert property (
      complete && q.full && !data_read
      |=> q.overrun && $stable(q.data_buf) && $stable(q.ninth))
      else $error("overrun replaced buffered character");

   ninth_copy_a: assert property (
      complete && !q.full && !nine && stop_ok
      |=> q.ninth == q.data_buf[7])
      else $error("ninth bit is not a copy of bit 7");

   phase_range_a: assert property (
      q.st != ST_HUNT |-> q.phase >= PH_FIRST && q.phase <= PH_LAST)
      else $error("oversample phase out of range");

endmodule
`default_nettype wire

// >>> core/sci_rx_pkg.sv
package sci_rx_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 50_000_000;
   localparam int BAUD_DEFAULT = 9600;
   localparam int OVERSAMPLE = 16;
   localparam logic [15:0] DIV_RST =
      16'(CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT) - 1);

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
   localparam logic [7:0] OFS_DATA = 8'h0c;
   localparam logic [7:0] OFS_STATUS_ONE = 8'h10;
   localparam int NINE_BIT_POS = 4;
   localparam int RX_ENABLE_POS = 6;
   localparam int IRQ_EN_POS = 5;
   localparam int NINTH_POS = 7;
   localparam int FULL_POS = 5;
   localparam int OVERRUN_POS = 3;
   localparam int NOISE_POS = 2;
   localparam int FRAME_POS = 1;
   localparam int BREAK_POS = 0;
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;

   // ----------------------------------------------------------------
   // Oversample phases
   // ----------------------------------------------------------------
   localparam logic [4:0] PH_FIRST = 5'h01;
   localparam logic [4:0] PH_AFTER_EDGE = 5'h02;
   localparam logic [4:0] PH_3 = 5'h03;
   localparam logic [4:0] PH_4 = 5'h04;
   localparam logic [4:0] PH_5 = 5'h05;
   localparam logic [4:0] PH_7 = 5'h07;
   localparam logic [4:0] PH_8 = 5'h08;
   localparam logic [4:0] PH_10 = 5'h0a;
   localparam logic [4:0] PH_11 = 5'h0b;
   localparam logic [4:0] PH_LAST = 5'h10;

   typedef enum logic [3:0] {
      ST_HUNT = 4'b0001,
      ST_START = 4'b0010,
      ST_DATA = 4'b0100,
      ST_STOP = 4'b1000
   } rx_state_t;

   function automatic logic majority3(input logic [2:0] v);
      return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction

   function automatic logic disagree3(input logic [2:0] v);
      return (v != 3'b000) && (v != 3'b111);
   endfunction

endpackage

// >>> core/sci_rx_if.sv
`timescale 1ns/100ps
`default_nettype none
interface sci_rx_if;
   logic rxd;
   logic tick;
   modport source (output rxd, output tick);
   modport sink (input rxd, input tick);
endinterface
`default_nettype wire

// >>> core/sci_rx_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module sci_rx_sampler
   import sci_rx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic rxd_pin,
   input wire logic [15:0] divisor,
   sci_rx_if.source smp
);

   typedef struct packed {
      logic meta;
      logic sync;
      logic [15:0] cnt;
      logic tick;
   } sampler_t;

   sampler_t q, d;

   // ----------------------------------------------------------------
   // Pin synchroniser and oversample enable
   // ----------------------------------------------------------------
   always_comb
   begin
      d = q;
      d.meta = rxd_pin;
      d.sync = q.meta;
      d.tick = 1'b0;
      if (q.cnt >= divisor)
      begin
         d.cnt = 16'h0000;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   // Line idles high, so the synchroniser resets to 1
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         q <= '{meta: 1'b1, sync: 1'b1, cnt: 16'h0000, tick: 1'b0};
      else
         q <= d;
   end

   assign smp.rxd = q.sync;
   assign smp.tick = q.tick;

endmodule
`default_nettype wire

// >>> test/sci_far_transmitter.sv
`timescale 1ns/100ps
`default_nettype none
module sci_far_transmitter
(
   input wire logic pclk,
   output var logic line
);

   // ----------------------------------------------------------------
   // Frame generator
   // ----------------------------------------------------------------
   // Line idles high, as the pulled-up receive pin does between frames
   initial line = 1'b1;

   task automatic hold(input logic v, input int n);
      line <= v;
      repeat (n) @(posedge pclk);
   endtask

   // Bit length is in pclk cycles, so a sender running slow or fast
   // is just a longer or shorter blen; glitch flips one tick mid-stop
   task automatic send(input logic [8:0] val, input int nbits,
      input int blen, input logic stop_v, input logic glitch);
      hold(1'b1, blen);
      hold(1'b0, blen);
      for (int i = 0; i < nbits; i++)
      begin
         hold(val[i], blen);
      end
      if (glitch)
      begin
         hold(stop_v, blen / 2);
         hold(~stop_v, 4);
         hold(stop_v, blen / 2 - 4);
      end
      else
      begin
         hold(stop_v, blen);
      end
      // Trailing idle refills the three-ones history before a new start
      hold(1'b1, 2 * blen);
   endtask

endmodule
`default_nettype wire

// >>> test/test_sci_async_receiver.sv
`timescale 1ns/100ps
`default_nettype none
module test_sci_async_receiver
   import sci_rx_pkg::*;
;
   typedef struct {
      logic nine;
      logic [8:0] val;
      int blen;
      logic stop_v;
      logic [7:0] e_data;
      logic e_ninth;
      logic frm;
      logic brk;
   } row_t;

   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic rxd_pin;
   logic rx_irq;
   logic [31:0] rd;
   logic err;
   int bad_count;
   int comparisons;
   logic [31:0] irq_on;

   // Bit length 64 pclk matches divisor 3 (tick every 4 pclk)
   row_t rows[8] = '{
      '{1'b0, 9'h0a5, 64, 1'b1, 8'ha5, 1'b1, 1'b0, 1'b0},
      '{1'b0, 9'h03c, 64, 1'b1, 8'h3c, 1'b0, 1'b0, 1'b0},
      '{1'b1, 9'h15a, 64, 1'b1, 8'h5a, 1'b1, 1'b0, 1'b0},
      '{1'b1, 9'h0ff, 64, 1'b1, 8'hff, 1'b0, 1'b0, 1'b0},
      '{1'b0, 9'h055, 64, 1'b0, 8'h55, 1'b0, 1'b1, 1'b0},
      '{1'b0, 9'h000, 64, 1'b0, 8'h00, 1'b0, 1'b1, 1'b1},
      '{1'b1, 9'h155, 66, 1'b1, 8'h55, 1'b1, 1'b0, 1'b0},
      '{1'b0, 9'h0aa, 62, 1'b1, 8'haa, 1'b1, 1'b0, 1'b0}
   };

   sci_async_receiver i_sci_async_receiver (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rxd_pin(rxd_pin),
      .rx_irq(rx_irq)
   );

   sci_far_transmitter far_tx (.pclk(pclk), .line(rxd_pin));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] st(input logic f, input logic o,
      input logic n, input logic fr, input logic b);
      return (32'(f) << FULL_POS) | (32'(o) << OVERRUN_POS) |
         (32'(n) << NOISE_POS) | (32'(fr) << FRAME_POS) |
         (32'(b) << BREAK_POS);
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done();
      $display("mismatches %0d comparisons %0d", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Request held from setup until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_irq();
      int n;
      n = 0;
      while (rx_irq !== 1'b1 && n < 2000)
      begin
         @(posedge pclk);
         n++;
      end
      chk({31'h0, rx_irq}, 32'h1);
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   initial
   begin
      repeat (40000) @(posedge pclk);
      bad_count++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      bad_count = 0;
      comparisons = 0;
      irq_on = 32'h1 << IRQ_EN_POS;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b1, OFS_CTRL_THREE, 32'h3);
      apb(1'b1, OFS_CTRL_TWO, irq_on);
      foreach (rows[i])
      begin
         apb(1'b1, OFS_CTRL_ONE, (32'h1 << RX_ENABLE_POS) |
            (32'(rows[i].nine) << NINE_BIT_POS));
         far_tx.send(rows[i].val, rows[i].nine ? 9 : 8, rows[i].blen,
            rows[i].stop_v, 1'b0);
         wait_irq();
         apb(1'b0, OFS_STATUS_ONE, 32'h0);
         chk(rd, st(1'b1, 1'b0, 1'b0, rows[i].frm, rows[i].brk));
         apb(1'b0, OFS_CTRL_TWO, 32'h0);
         chk(rd, (32'(rows[i].e_ninth) << NINTH_POS) | irq_on);
         apb(1'b0, OFS_DATA, 32'h0);
         chk(rd, 32'(rows[i].e_data));
         apb(1'b0, OFS_STATUS_ONE, 32'h0);
         chk(rd, 32'h0);
      end
      // Masked interrupt, then overrun while the first is unread
      apb(1'b1, OFS_CTRL_TWO, 32'h0);
      far_tx.send(9'h011, 8, 64, 1'b1, 1'b0);
      chk({31'h0, rx_irq}, 32'h0);
      apb(1'b1, OFS_CTRL_TWO, irq_on);
      wait_irq();
      far_tx.send(9'h022, 8, 64, 1'b1, 1'b0);
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, st(1'b1, 1'b1, 1'b0, 1'b0, 1'b0));
      apb(1'b1, OFS_DATA, 32'h000000ee);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'h00000011);
      // One bad stop sample: noise only, no framing error
      far_tx.send(9'h00f, 8, 64, 1'b1, 1'b1);
      wait_irq();
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'h0000000f);
      // Short low pulse fails start check; hunt restarts for next frame
      far_tx.hold(1'b0, 8);
      far_tx.hold(1'b1, 256);
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, 32'h0);
      far_tx.send(9'h081, 8, 64, 1'b1, 1'b0);
      wait_irq();
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'h00000081);
      // One high sample at phase 8 of the start bit: noise, start kept
      far_tx.hold(1'b1, 64);
      far_tx.hold(1'b0, 28);
      far_tx.hold(1'b1, 4);
      far_tx.hold(1'b0, 32);
      far_tx.hold(1'b1, 704);
      wait_irq();
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0));
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'h000000ff);
      chk({31'h0, err}, 32'h0);
      // Receiver disabled ignores the line
      apb(1'b1, OFS_CTRL_ONE, 32'h0);
      far_tx.send(9'h033, 8, 64, 1'b1, 1'b0);
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      // Second reset in mid-run restores reset values
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk({31'h0, rx_irq}, 32'h0);
      chk({31'h0, pready}, 32'h1);
      apb(1'b0, OFS_CTRL_ONE, 32'h0);
      chk(rd, 32'(CTRL_ONE_RST));
      apb(1'b0, OFS_CTRL_TWO, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_CTRL_THREE, 32'h0);
      chk(rd, 32'(DIV_RST));
      apb(1'b0, OFS_STATUS_ONE, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, OFS_DATA, 32'h0);
      chk(rd, 32'h0);
      test_done();
   end

endmodule
`default_nettype wire
